// ### verilog/bkcfg_regs.vh
// register offsets, field positions and reset values of the buck one configuration slice
`ifndef BKCFG_REGS_VH
`define BKCFG_REGS_VH
// ==========================================================
// register offsets
`define BKCFG_ADDR_CONFIG_B 8'h1d
`define BKCFG_ADDR_PEAK_CUR 8'h1e
`define BKCFG_ADDR_OUT_VOLT 8'h1f
// ==========================================================
// field positions
`define BKCFG_BIT_PIN_FAST 5
`define BKCFG_BIT_FORCED_PWM 4
`define BKCFG_BIT_ADAPT_OFF 3
`define BKCFG_BIT_TABLE_BYPASS 7
`define BKCFG_PEAK_MSB 3
`define BKCFG_VOLT_MSB 5
// ==========================================================
// writable masks and reset values
`define BKCFG_MASK_CONFIG_B 8'h38
`define BKCFG_MASK_PEAK_CUR 8'h8f
`define BKCFG_MASK_OUT_VOLT 8'h3f
`define BKCFG_RST_CONFIG_B 8'h00
`define BKCFG_RST_PEAK_CUR 8'h00
`define BKCFG_RST_OUT_VOLT 8'h00
// ==========================================================
// scaling constants
`define BKCFG_PEAK_STEP_MA 16'h0019
`define BKCFG_VOLT_BASE_MV 16'h0226
`endif

// ### verilog/bkcfg_reg8.v
// one 8-bit configuration register with a writable-bit mask
`timescale 1ns/1ps
`default_nettype none
module bkcfg_reg8 #(
  parameter [7:0] ADDR = 8'h00,
  parameter [7:0] MASK = 8'hff,
  parameter [7:0] RSTV = 8'h00
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // write port
  input wire wrEn,
  input wire [7:0] wrAddr,
  input wire [7:0] wrData,
  // stored value
  output reg [7:0] value_r
);
  // masked write, reserved bits stay zero
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      value_r <= RSTV;
    end else if (wrEn && (wrAddr == ADDR)) begin
      value_r <= wrData & MASK;
    end
  end
endmodule
`default_nettype wire

// ### verilog/bkcfg_regs_top.v
// configuration register slice for buck one: registers and decoded controls
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
`include "bkcfg_regs.vh"
module bkcfg_regs_top (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // register access port from the configuration interface
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData_r,
  output reg regRdValid_r,
  // multipurpose pin two level
  input wire multipurposePinTwo,
  // voltage step size in mV, from another register
  input wire [5:0] voltageStepSize,
  // controls to the regulator
  output reg fastModeReq_r,
  output reg forcedPwmSelect_r,
  output reg adaptivePeakEn_r,
  output reg tableCurrentEn_r,
  output reg [3:0] peakCurrentCode_r,
  output reg [15:0] peakCurrentMa_r,
  output reg [5:0] outputVoltageCode_r,
  output reg [15:0] outputVoltageMv_r
);
  // ==========================================================
  // register map, reserved bits read back as zero
  // 0x1d bit 5 pin fast mode allow, bit 4 forced pwm select
  // 0x1d bit 3 adaptive peak off, bits 7:6 and 2:0 reserved
  // 0x1e bit 7 table current bypass, bits 6:4 reserved
  // 0x1e bits 3:0 peak current code, 25 mA per step
  // 0x1f bits 5:0 output voltage code, bits 7:6 reserved
  // all three reset to zero: pin gate off, normal switching,
  // adaptive peak on, lookup table on, lowest voltage
  // writes to other addresses are dropped

  // ==========================================================
  // register storage
  // one instance per register, each with its own writable mask
  wire [7:0] cfgB;
  wire [7:0] peakCur;
  wire [7:0] outVolt;
  wire pinFastModeAllow;
  wire adaptivePeakOff;
  wire tableCurrentBypass;
  wire [3:0] peakCode;
  wire [5:0] voltCode;
  wire [15:0] peakMaNxt;
  wire [15:0] voltMvNxt;
  wire [15:0] peakCodeWide;
  wire [15:0] voltCodeWide;
  wire [15:0] voltStepWide;
  wire [15:0] voltOffsetMv;
  reg [7:0] rdNxt;

  bkcfg_reg8 #(
    .ADDR(`BKCFG_ADDR_CONFIG_B),
    .MASK(`BKCFG_MASK_CONFIG_B),
    .RSTV(`BKCFG_RST_CONFIG_B)
  ) uCfgB (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(regWrEn),
    .wrAddr(regAddr),
    .wrData(regWrData),
    .value_r(cfgB)
  );

  bkcfg_reg8 #(
    .ADDR(`BKCFG_ADDR_PEAK_CUR),
    .MASK(`BKCFG_MASK_PEAK_CUR),
    .RSTV(`BKCFG_RST_PEAK_CUR)
  ) uPeakCur (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(regWrEn),
    .wrAddr(regAddr),
    .wrData(regWrData),
    .value_r(peakCur)
  );

  bkcfg_reg8 #(
    .ADDR(`BKCFG_ADDR_OUT_VOLT),
    .MASK(`BKCFG_MASK_OUT_VOLT),
    .RSTV(`BKCFG_RST_OUT_VOLT)
  ) uOutVolt (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(regWrEn),
    .wrAddr(regAddr),
    .wrData(regWrData),
    .value_r(outVolt)
  );

  // ==========================================================
  // field extraction
  assign pinFastModeAllow = cfgB[`BKCFG_BIT_PIN_FAST];
  assign adaptivePeakOff = cfgB[`BKCFG_BIT_ADAPT_OFF];
  assign tableCurrentBypass = peakCur[`BKCFG_BIT_TABLE_BYPASS];
  assign peakCode = peakCur[`BKCFG_PEAK_MSB:0];
  assign voltCode = outVolt[`BKCFG_VOLT_MSB:0];

  // ==========================================================
  // scaled levels
  // linear peak scale
  assign peakCodeWide = {12'h000, peakCode};
  assign peakMaNxt = peakCodeWide * `BKCFG_PEAK_STEP_MA;
  // linear voltage scale
  // sixteen bits hold the largest level, 550 plus 63 times 63
  assign voltCodeWide = {10'h000, voltCode};
  assign voltStepWide = {10'h000, voltageStepSize};
  assign voltOffsetMv = voltCodeWide * voltStepWide;
  assign voltMvNxt = `BKCFG_VOLT_BASE_MV + voltOffsetMv;

  // ==========================================================
  // read-back decode, unmapped reads return zero
  always @* begin
    if (regAddr == `BKCFG_ADDR_CONFIG_B) begin
      rdNxt = cfgB;
    end else if (regAddr == `BKCFG_ADDR_PEAK_CUR) begin
      rdNxt = peakCur;
    end else if (regAddr == `BKCFG_ADDR_OUT_VOLT) begin
      rdNxt = outVolt;
    end else begin
      rdNxt = 8'h00;
    end
  end

  // read data register, one-cycle valid
  // a read and a write in one cycle return the old byte
  // read data holds until the next read strobe
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regRdData_r <= 8'h00;
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRdEn;
      if (regRdEn) begin
        regRdData_r <= rdNxt;
      end
    end
  end

  // ==========================================================
  // registered regulator controls
  // each control lags its register field by one clock
  // pin fast gate
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fastModeReq_r <= 1'b0;
    end else begin
      fastModeReq_r <= pinFastModeAllow & multipurposePinTwo;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      forcedPwmSelect_r <= 1'b0;
    end else begin
      forcedPwmSelect_r <= cfgB[`BKCFG_BIT_FORCED_PWM];
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      adaptivePeakEn_r <= 1'b1;
    end else begin
      adaptivePeakEn_r <= ~adaptivePeakOff;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tableCurrentEn_r <= 1'b1;
    end else begin
      tableCurrentEn_r <= ~tableCurrentBypass;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      peakCurrentCode_r <= 4'h0;
      peakCurrentMa_r <= 16'h0000;
    end else begin
      peakCurrentCode_r <= peakCode;
      // table selected: the code is ignored, so report zero
      peakCurrentMa_r <= tableCurrentBypass ? peakMaNxt : 16'h0000;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      outputVoltageCode_r <= 6'h00;
      outputVoltageMv_r <= `BKCFG_VOLT_BASE_MV;
    end else begin
      outputVoltageCode_r <= voltCode;
      outputVoltageMv_r <= voltMvNxt;
    end
  end
endmodule
`default_nettype wire

// ### verif/bkcfg_regs_checker.sv
// port assertions for the buck one config slice
`timescale 1ns/1ps
`default_nettype none
module bkcfg_regs_checker (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // register writes
  input wire regWrEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  // pin and step
  input wire multipurposePinTwo,
  input wire [5:0] voltageStepSize,
  // controls
  input wire fastModeReq_r,
  input wire forcedPwmSelect_r,
  input wire adaptivePeakEn_r,
  input wire tableCurrentEn_r,
  input wire [3:0] peakCurrentCode_r,
  input wire [15:0] peakCurrentMa_r,
  input wire [5:0] outputVoltageCode_r,
  input wire [15:0] outputVoltageMv_r
);
  // =====
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_fast_needs_pin: assert property (fastModeReq_r |-> $past(multipurposePinTwo))
    else $error("fast mode raised without pin");
  chk_pwm_follows: assert property (regWrEn && regAddr == 8'h1d |->
    ##2 forcedPwmSelect_r == $past(regWrData[4], 2))
    else $error("forced pwm wrong");
  chk_adapt_follows: assert property (regWrEn && regAddr == 8'h1d |->
    ##2 adaptivePeakEn_r != $past(regWrData[3], 2))
    else $error("adaptive peak wrong");
  chk_table_follows: assert property (regWrEn && regAddr == 8'h1e |->
    ##2 tableCurrentEn_r != $past(regWrData[7], 2))
    else $error("table select wrong");
  chk_peak_scale: assert property (peakCurrentMa_r ==
    (tableCurrentEn_r ? 16'h0000 : peakCurrentCode_r * 16'h0019))
    else $error("peak current wrong");
  chk_volt_scale: assert property ($stable(voltageStepSize) |=>
    outputVoltageMv_r == 16'h0226 + outputVoltageCode_r * $past(voltageStepSize))
    else $error("output voltage wrong");
endmodule
`default_nettype wire

// ### verif/tb.sv
// random bench for the buck one config slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin badCount++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  reg clk_sys = 1'b0, rst_b = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, multipurposePinTwo = 1'b0;
  reg [7:0] regAddr = 8'h00, regWrData = 8'h00, a, d;
  reg [5:0] voltageStepSize = 6'h0a;
  reg [7:0] m [3];
  wire [7:0] regRdData_r;
  wire regRdValid_r, fastModeReq_r, forcedPwmSelect_r, adaptivePeakEn_r, tableCurrentEn_r;
  wire [3:0] peakCurrentCode_r;
  wire [15:0] peakCurrentMa_r, outputVoltageMv_r;
  wire [5:0] outputVoltageCode_r;
  int badCount = 0, checksDone = 0;
  // =====
  // clock and design
  always #5 clk_sys = ~clk_sys;
  bkcfg_regs_top dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData_r(regRdData_r),
    .regRdValid_r(regRdValid_r),
    .multipurposePinTwo(multipurposePinTwo),
    .voltageStepSize(voltageStepSize),
    .fastModeReq_r(fastModeReq_r),
    .forcedPwmSelect_r(forcedPwmSelect_r),
    .adaptivePeakEn_r(adaptivePeakEn_r),
    .tableCurrentEn_r(tableCurrentEn_r),
    .peakCurrentCode_r(peakCurrentCode_r),
    .peakCurrentMa_r(peakCurrentMa_r),
    .outputVoltageCode_r(outputVoltageCode_r),
    .outputVoltageMv_r(outputVoltageMv_r)
  );
  task automatic stopTest;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input [7:0] ad, input [7:0] dt);
    @(negedge clk_sys);
    regWrEn = 1'b1;
    regAddr = ad;
    regWrData = dt;
    @(negedge clk_sys);
    regWrEn = 1'b0;
  endtask
  // read answers one cycle after the strobe
  task automatic rd(input [7:0] ad, input [7:0] ex);
    @(negedge clk_sys);
    regRdEn = 1'b1;
    regAddr = ad;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    `CHK("valid", 1'b1, regRdValid_r)
    `CHK("rdata", ex, regRdData_r)
  endtask
  // stored value after the writable mask
  function automatic [7:0] msk(input [7:0] ad, input [7:0] dt);
    msk = ad == 8'h1d ? dt & 8'h38 : ad == 8'h1e ? dt & 8'h8f : ad == 8'h1f ? dt & 8'h3f : 8'h00;
  endfunction
  initial begin
    #100000;
    badCount++;
    stopTest;
  end
  // =====
  // main sequence
  initial begin
    void'($urandom(32'h01ec));
    m = '{8'h00, 8'h00, 8'h00};
    repeat (16) @(negedge clk_sys);
    // reset values of every control
    `CHK("rst fast", 1'b0, fastModeReq_r)
    `CHK("rst pwm", 1'b0, forcedPwmSelect_r)
    `CHK("rst adapt", 1'b1, adaptivePeakEn_r)
    `CHK("rst table", 1'b1, tableCurrentEn_r)
    `CHK("rst code", 4'h0, peakCurrentCode_r)
    `CHK("rst ma", 16'h0000, peakCurrentMa_r)
    `CHK("rst vcode", 6'h00, outputVoltageCode_r)
    `CHK("rst mv", 16'h0226, outputVoltageMv_r)
    rst_b = 1'b1;
    for (int i = 0; i < 80; i++) begin
      a = i < 10 ? 8'h1c + 8'(i % 5) : 8'h1c + 8'($urandom % 5);
      d = i < 5 ? 8'hff : i < 10 ? 8'h00 : 8'($urandom);
      multipurposePinTwo = 1'($urandom);
      voltageStepSize = 6'($urandom);
      wr(a, d);
      if (a >= 8'h1d && a <= 8'h1f) m[a - 8'h1d] = msk(a, d);
      rd(a, (a >= 8'h1d && a <= 8'h1f) ? m[a - 8'h1d] : 8'h00);
      @(negedge clk_sys);
      `CHK("fast", m[0][5] & multipurposePinTwo, fastModeReq_r)
      `CHK("pwm", m[0][4], forcedPwmSelect_r)
      `CHK("adapt", ~m[0][3], adaptivePeakEn_r)
      `CHK("table", ~m[1][7], tableCurrentEn_r)
      `CHK("ma", m[1][7] ? m[1][3:0] * 16'h0019 : 16'h0000, peakCurrentMa_r)
      `CHK("ma code", m[1][3:0], peakCurrentCode_r)
      `CHK("mv", 16'h0226 + m[2][5:0] * voltageStepSize, outputVoltageMv_r)
      `CHK("mv code", m[2][5:0], outputVoltageCode_r)
    end
    // read and write in one cycle: the read returns the old byte
    @(negedge clk_sys);
    regWrEn = 1'b1;
    regRdEn = 1'b1;
    regAddr = 8'h1f;
    regWrData = 8'hff;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    `CHK("old rdata", m[2], regRdData_r)
    m[2] = 8'h3f;
    rd(8'h1f, m[2]);
    @(negedge clk_sys);
    `CHK("mv top", 16'h0226 + 16'h003f * voltageStepSize, outputVoltageMv_r)
    stopTest;
  end
endmodule
bind bkcfg_regs_top bkcfg_regs_checker chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .regWrEn(regWrEn),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .multipurposePinTwo(multipurposePinTwo),
  .voltageStepSize(voltageStepSize),
  .fastModeReq_r(fastModeReq_r),
  .forcedPwmSelect_r(forcedPwmSelect_r),
  .adaptivePeakEn_r(adaptivePeakEn_r),
  .tableCurrentEn_r(tableCurrentEn_r),
  .peakCurrentCode_r(peakCurrentCode_r),
  .peakCurrentMa_r(peakCurrentMa_r),
  .outputVoltageCode_r(outputVoltageCode_r),
  .outputVoltageMv_r(outputVoltageMv_r)
);
`default_nettype wire
